// *** rtl/dtc_cfg.svh ***
// Register map, field positions, reset values and prescale constants.
// Assumes inclusion by bare name; definitions only.
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH
`define DTC_OFF_A_MODE 8'h00
`define DTC_OFF_A_DATA 8'h04
`define DTC_OFF_B_MODE 8'h08
`define DTC_OFF_B_DATA 8'h0c
`define DTC_OFF_PERIOD 8'h10
`define DTC_OFF_DUTY 8'h14
`define DTC_OFF_HIGH 8'h18
`define DTC_OFF_PINS 8'h1c
`define DTC_OFF_FLAGS 8'h20
// Mode A bits
`define DTC_A_RESTART 0
`define DTC_A_RUN 1
`define DTC_A_CK_LO 2
`define DTC_A_CAP 5
// Mode B bits
`define DTC_B_RESTART 0
`define DTC_B_RUN 1
`define DTC_B_CK_LO 2
`define DTC_B_CAP 4
`define DTC_B_PWM 5
`define DTC_B_WIDE 6
`define DTC_B_POL 7
// Pin register: edge selects and pin function
`define DTC_P_EDGE_A 0
`define DTC_P_EDGE_B 2
`define DTC_P_FUNC 4
`define DTC_EDGE_FALL 2'h1
`define DTC_EDGE_RISE 2'h2
`define DTC_EDGE_BOTH 2'h3
`define DTC_CK_EVENT 3'h7
`define DTC_CK_CHAIN 2'h3
`define DTC_RESET_BYTE 8'h00
`endif

// *** rtl/dtc_pkg.sv ***
// Types for the dual timer block.
// Assumes the cfg header supplies numeric constants.
package dtc_pkg;
    typedef enum logic [1:0] {dtc_resp_okay = 2'h0,
                              dtc_resp_slverr = 2'h2} dtc_resp_t;
endpackage : dtc_pkg

// *** rtl/dtc_timer.sv ***
// Two 8-bit timers, chainable to 16 bits, with capture, compare and PWM.
// Assumes synchronous pins and an AXI4-Lite master with one access at once.
//
// Summary of operation
// - Timer A prescaler divides by 2,4,8,32,128,512 or 2048.
// - Timer B clock select offers divide by 1, 2 or 8.
// - 8-bit count rises from zero, clears on match; each match flags its own timer.
// - Count and match share one address: read count, write match.
// - Timer A counts each rising edge of the event pin.
// - Timer B counts the event pin only through the timer A clock.
// - Chained 16-bit count clears on match, flagging only timer A.
// - Compare mode toggles the output pin on every timer B match, or on the 16-bit match when chained.
// - Each timer has its own capture enable bit.
// - Capture edge copies count into capture register, clears count.
// - Capture edge selectable falling, rising or both; raises interrupt.
// - In capture mode the match still clears count and flags.
// - In capture mode the shared address reads the capture register.
// - Timer B drives a 10-bit PWM on the shared pin.
// - Period and duty are ten bits from high register and low register.
// - Duty is double buffered, loaded when count matches period.
// - Polarity sets duty level; full duty holds it, zero duty opposite.
// - New duty applies after current period; period must exceed duty.
// - Timer B clock select 11 uses the timer A clock.
// - Writing restart one clears and runs; run and restart both zero stops.
`timescale 1ns/1ps
`include "dtc_cfg.svh"
module dtc_timer #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic event_count_pin,
    input wire logic [1:0] capture_trigger_pin,
    output logic compare_out_pin,
    output logic timer_a_irq,
    output logic timer_b_irq,
    output logic [1:0] ext_irq
);
    logic [7:0] timer_a_mode_reg, timer_b_mode_reg;
    logic [7:0] timer_a_match_reg, timer_b_match_reg;
    logic [7:0] timer_a_count, timer_b_count;
    logic [7:0] timer_a_capture_reg, timer_b_capture_reg;
    logic [7:0] pulse_period_low_reg, pulse_duty_low_reg, a_match_flags;
    logic [3:0] pulse_high_bits_reg, w_strb;
    logic [4:0] pin_reg;
    logic [9:0] duty_active, pwm_count, period_full;
    logic [10:0] prescale, next_prescale;
    logic [2:0] timer_a_clock_sel;
    logic [1:0] timer_b_clock_sel, trig_q, cap_edge;
    logic timer_a_capture_sel, timer_b_capture_sel, chain_wide_sel;
    logic pulse_mod_enable, duty_active_level, pulse_pin_function_bit;
    logic event_q, tick_a, tick_b, match_a, match_b, match_w, pwm_wrap;
    logic have_aw, have_w, wr_fire, wr_a_data, wr_b_data;
    logic wr_a_mode, wr_b_mode, next_rerr;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data, next_rdata;

    assign timer_a_clock_sel = timer_a_mode_reg[`DTC_A_CK_LO +: 3];
    assign timer_b_clock_sel = timer_b_mode_reg[`DTC_B_CK_LO +: 2];
    assign timer_a_capture_sel = timer_a_mode_reg[`DTC_A_CAP];
    assign timer_b_capture_sel = timer_b_mode_reg[`DTC_B_CAP];
    assign chain_wide_sel = timer_b_mode_reg[`DTC_B_WIDE];
    assign pulse_mod_enable = timer_b_mode_reg[`DTC_B_PWM];
    assign duty_active_level = timer_b_mode_reg[`DTC_B_POL];
    assign pulse_pin_function_bit = pin_reg[`DTC_P_FUNC];
    assign period_full = {pulse_high_bits_reg[3:2], pulse_period_low_reg};

    // Free-running prescaler; each tap's carry is a one-cycle enable
    assign next_prescale = prescale + 11'h001;
    always_ff @(posedge aclk) begin
        if (!aresetn)
            prescale <= 11'h000;
        else
            prescale <= next_prescale;
    end

    function automatic logic tap(input logic [10:0] p, input int n);
        logic [10:0] m;
        m = (11'h001 << n) - 11'h001;
        return (p & m) == m;
    endfunction : tap

    always_comb begin
        case (timer_a_clock_sel)
            3'h0: tick_a = tap(prescale, 1);
            3'h1: tick_a = tap(prescale, 2);
            3'h2: tick_a = tap(prescale, 3);
            3'h3: tick_a = tap(prescale, 5);
            3'h4: tick_a = tap(prescale, 7);
            3'h5: tick_a = tap(prescale, 9);
            3'h6: tick_a = tap(prescale, 11);
            default: tick_a = event_count_pin & ~event_q;
        endcase
        tick_a = tick_a & timer_a_mode_reg[`DTC_A_RUN];
    end

    always_comb begin
        case (timer_b_clock_sel)
            2'h0: tick_b = 1'b1;
            2'h1: tick_b = tap(prescale, 1);
            2'h2: tick_b = tap(prescale, 3);
            default: tick_b = tick_a;
        endcase
        tick_b = tick_b & timer_b_mode_reg[`DTC_B_RUN];
    end

    // Edge detect on synchronous pins; edge mode per timer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_q <= 1'b0;
            trig_q <= 2'h0;
        end else begin
            event_q <= event_count_pin;
            trig_q <= capture_trigger_pin;
        end
    end

    for (genvar i = 0; i < 2; i++) begin : g_edge
        logic [1:0] sel;
        assign sel = pin_reg[2*i +: 2];
        assign cap_edge[i] =
            ((sel == `DTC_EDGE_FALL) & trig_q[i] & ~capture_trigger_pin[i]) |
            ((sel == `DTC_EDGE_RISE) & ~trig_q[i] & capture_trigger_pin[i]) |
            ((sel == `DTC_EDGE_BOTH) & (trig_q[i] ^ capture_trigger_pin[i]));
    end

    assign match_a = tick_a && timer_a_count == timer_a_match_reg;
    assign match_b = tick_b && timer_b_count == timer_b_match_reg;
    assign match_w = tick_a && {timer_b_count, timer_a_count} ==
                     {timer_b_match_reg, timer_a_match_reg};
    assign pwm_wrap = tick_b && pwm_count == period_full;

    // Register write path: address and data latched in either order
    assign wr_fire = have_aw && have_w && !s_axi_bvalid;
    assign wr_a_mode = wr_fire && aw_addr == `DTC_OFF_A_MODE && w_strb[0];
    assign wr_b_mode = wr_fire && aw_addr == `DTC_OFF_B_MODE && w_strb[0];
    assign wr_a_data = wr_fire && aw_addr == `DTC_OFF_A_DATA && w_strb[0];
    assign wr_b_data = wr_fire && aw_addr == `DTC_OFF_B_DATA && w_strb[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            have_aw <= 1'b0;
            have_w <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= !have_aw && !s_axi_awready;
            s_axi_wready <= !have_w && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                have_aw <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                have_w <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                have_aw <= 1'b0;
                have_w <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr > `DTC_OFF_FLAGS || aw_addr[1:0] != 2'h0)
                    ? dtc_pkg::dtc_resp_slverr : dtc_pkg::dtc_resp_okay;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Config registers; restart bits self-clear after one cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_a_mode_reg <= `DTC_RESET_BYTE;
            timer_b_mode_reg <= `DTC_RESET_BYTE;
            timer_a_match_reg <= `DTC_RESET_BYTE;
            timer_b_match_reg <= `DTC_RESET_BYTE;
            pulse_period_low_reg <= `DTC_RESET_BYTE;
            pulse_duty_low_reg <= `DTC_RESET_BYTE;
            pulse_high_bits_reg <= 4'h0;
            pin_reg <= 5'h00;
        end else begin
            timer_a_mode_reg[`DTC_A_RESTART] <= 1'b0;
            timer_b_mode_reg[`DTC_B_RESTART] <= 1'b0;
            if (wr_a_mode) begin
                timer_a_mode_reg <= w_data[7:0] & 8'h3f;
                timer_a_mode_reg[`DTC_A_RUN] <= w_data[`DTC_A_RUN] |
                                               w_data[`DTC_A_RESTART];
            end
            if (wr_b_mode) begin
                timer_b_mode_reg <= w_data[7:0];
                timer_b_mode_reg[`DTC_B_RUN] <= w_data[`DTC_B_RUN] |
                                               w_data[`DTC_B_RESTART];
            end
            if (wr_a_data)
                timer_a_match_reg <= w_data[7:0];
            if (wr_b_data)
                timer_b_match_reg <= w_data[7:0];
            if (wr_fire && w_strb[0]) begin
                case (aw_addr)
                    `DTC_OFF_PERIOD: pulse_period_low_reg <= w_data[7:0];
                    `DTC_OFF_DUTY: pulse_duty_low_reg <= w_data[7:0];
                    `DTC_OFF_HIGH: pulse_high_bits_reg <= w_data[3:0];
                    `DTC_OFF_PINS: pin_reg <= w_data[4:0];
                    default: ;
                endcase
            end
        end
    end

    // Timer A count and capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_a_count <= 8'h00;
            timer_a_capture_reg <= 8'h00;
        end else if (wr_a_mode && w_data[`DTC_A_RESTART]) begin
            timer_a_count <= 8'h00;
        end else if (timer_a_capture_sel && cap_edge[0]) begin
            timer_a_capture_reg <= timer_a_count;
            timer_a_count <= 8'h00;
        end else if (chain_wide_sel ? match_w : match_a) begin
            timer_a_count <= 8'h00;
        end else if (tick_a) begin
            timer_a_count <= timer_a_count + 8'h01;
        end
    end

    // Timer B count and capture; carries from A when chained
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_b_count <= 8'h00;
            timer_b_capture_reg <= 8'h00;
        end else if (wr_b_mode && w_data[`DTC_B_RESTART]) begin
            timer_b_count <= 8'h00;
        end else if (chain_wide_sel) begin
            if (timer_a_capture_sel && cap_edge[0]) begin
                timer_b_capture_reg <= timer_b_count;
                timer_b_count <= 8'h00;
            end else if (match_w) begin
                timer_b_count <= 8'h00;
            end else if (tick_a && timer_a_count == 8'hff) begin
                timer_b_count <= timer_b_count + 8'h01;
            end
        end else if (timer_b_capture_sel && cap_edge[1]) begin
            timer_b_capture_reg <= timer_b_count;
            timer_b_count <= 8'h00;
        end else if (match_b) begin
            timer_b_count <= 8'h00;
        end else if (tick_b) begin
            timer_b_count <= timer_b_count + 8'h01;
        end
    end

    // PWM counter and duty double buffer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_count <= 10'h000;
            duty_active <= 10'h000;
        end else if (!pulse_mod_enable) begin
            pwm_count <= 10'h000;
            duty_active <= {pulse_high_bits_reg[1:0], pulse_duty_low_reg};
        end else if (pwm_wrap) begin
            pwm_count <= 10'h000;
            duty_active <= {pulse_high_bits_reg[1:0], pulse_duty_low_reg};
        end else if (tick_b) begin
            pwm_count <= pwm_count + 10'h001;
        end
    end

    // Output pin: PWM level or compare toggle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare_out_pin <= 1'b0;
        end else if (!pulse_pin_function_bit) begin
            compare_out_pin <= 1'b0;
        end else if (pulse_mod_enable) begin
            compare_out_pin <= (pwm_count < duty_active) ? duty_active_level
                                                         : ~duty_active_level;
            if (duty_active >= period_full && duty_active != 10'h000)
                compare_out_pin <= duty_active_level;
        end else if (chain_wide_sel ? match_w : match_b) begin
            compare_out_pin <= ~compare_out_pin;
        end
    end

    // Event pulses; timer B match never fires in chained mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_a_irq <= 1'b0;
            timer_b_irq <= 1'b0;
            ext_irq <= 2'h0;
        end else begin
            timer_a_irq <= chain_wide_sel ? match_w : match_a;
            timer_b_irq <= !chain_wide_sel && match_b;
            ext_irq <= cap_edge;
        end
    end

    // Sticky event flags readable by software; reading clears, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn)
            a_match_flags <= 8'h00;
        else if (s_axi_arvalid && s_axi_arready &&
                 s_axi_araddr == `DTC_OFF_FLAGS)
            a_match_flags <= {4'h0, cap_edge, timer_b_irq, timer_a_irq};
        else
            a_match_flags <= a_match_flags |
                             {4'h0, cap_edge, timer_b_irq, timer_a_irq};
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rerr = 1'b0;
        case (s_axi_araddr)
            `DTC_OFF_A_MODE: next_rdata[7:0] = timer_a_mode_reg;
            `DTC_OFF_B_MODE: next_rdata[7:0] = timer_b_mode_reg;
            `DTC_OFF_A_DATA: next_rdata[7:0] = timer_a_capture_sel
                ? timer_a_capture_reg : timer_a_count;
            `DTC_OFF_B_DATA: next_rdata[7:0] =
                (timer_b_capture_sel || (chain_wide_sel && timer_a_capture_sel))
                ? timer_b_capture_reg : timer_b_count;
            `DTC_OFF_PERIOD: next_rdata[7:0] = pulse_period_low_reg;
            `DTC_OFF_DUTY: next_rdata[7:0] = pulse_duty_low_reg;
            `DTC_OFF_HIGH: next_rdata[3:0] = pulse_high_bits_reg;
            `DTC_OFF_PINS: next_rdata[4:0] = pin_reg;
            `DTC_OFF_FLAGS: next_rdata[7:0] = a_match_flags;
            default: next_rerr = 1'b1;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= next_rerr ? dtc_pkg::dtc_resp_slverr
                                         : dtc_pkg::dtc_resp_okay;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : dtc_timer

// *** tb/dtc_pin_model.sv ***
// Far-side model: drives the event pin and the two capture trigger pins.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
module dtc_pin_model (
    input wire logic aclk,
    output logic event_count_pin,
    output logic [1:0] capture_trigger_pin
);
    initial begin
        event_count_pin = 1'b0;
        capture_trigger_pin = 2'h0;
    end

    // Levels held two cycles so no edge is lost to pin sampling
    task automatic events(input int n);
        repeat (n) begin
            repeat (2) @(posedge aclk);
            event_count_pin <= 1'b1;
            repeat (2) @(posedge aclk);
            event_count_pin <= 1'b0;
        end
        repeat (4) @(posedge aclk);
    endtask : events

    task automatic pulse(input int b);
        repeat (2) @(posedge aclk);
        capture_trigger_pin[b] <= 1'b1;
        repeat (4) @(posedge aclk);
        capture_trigger_pin[b] <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask : pulse
endmodule : dtc_pin_model

// *** tb/dtc_timer_checker.sv ***
// Port-level checks of the dual timer block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module dtc_timer_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] capture_trigger_pin,
    input wire logic timer_a_irq,
    input wire logic timer_b_irq,
    input wire logic [1:0] ext_irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // Edge pulse lags the pin by one sample
    sequence pin_moved;
        $past(capture_trigger_pin[0]) != $past(capture_trigger_pin[0], 2);
    endsequence

    chk_b_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response missing");
    chk_r_answer: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read response missing");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read response dropped");
    chk_aw_drop: assert property (s_axi_awvalid && s_axi_awready
        |=> !s_axi_awready)
        else $error("address ready held after take");
    chk_err_zero: assert property (s_axi_rvalid
        && s_axi_rresp == dtc_pkg::dtc_resp_slverr |-> s_axi_rdata == 32'h0)
        else $error("refused read returned data");
    chk_reset_quiet: assert property ($rose(aresetn) |-> !timer_a_irq
        && !timer_b_irq && ext_irq == 2'h0 && !s_axi_bvalid && !s_axi_rvalid)
        else $error("output active out of reset");
    chk_ext_edge: assert property (ext_irq[0] |-> pin_moved)
        else $error("capture interrupt without pin edge");
endmodule : dtc_timer_checker

// *** tb/tb_top.sv ***
// Self-checking bench for the dual timer block.
// Assumes the pin model on the far side and an AXI4-Lite master here.
`timescale 1ns/1ps
`include "dtc_cfg.svh"
module tb_top;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] q;
        logic [1:0] r;
    } dtc_row_t;
    localparam logic [1:0] OK = dtc_pkg::dtc_resp_okay;
    localparam logic [1:0] ERR = dtc_pkg::dtc_resp_slverr;
    dtc_row_t rows [5];
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, cmp_q = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, cmp, a_irq, b_irq, ev;
    logic [1:0] bresp, rresp, ext_irq, cap, rs;
    logic [31:0] rdata, rd;
    int fail_count = 0, cmp_count = 0;
    int b_hits = 0, x_hits = 0, n, h;
    int ediv [7] = '{2, 4, 8, 32, 128, 512, 2048};
    int bdiv [3] = '{1, 2, 8};
    int enum_hits [3] = '{1, 1, 2};

    always #2 aclk = ~aclk;
    always @(posedge aclk) begin
        cmp_q <= cmp;
        if (b_irq === 1'b1) b_hits <= b_hits + 1;
        if (ext_irq[0] === 1'b1) x_hits <= x_hits + 1;
    end

    dtc_timer u_dtc_timer (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .event_count_pin(ev), .capture_trigger_pin(cap),
        .compare_out_pin(cmp), .timer_a_irq(a_irq), .timer_b_irq(b_irq),
        .ext_irq(ext_irq));
    dtc_pin_model u_dtc_pin_model (.aclk(aclk), .event_count_pin(ev),
        .capture_trigger_pin(cap));

    task automatic check(input string nm, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", nm, e, s);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int t = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && t < 100);
        bready <= 1'b0;
        rs = bresp;
        if (t >= 100) fail_count++;
    endtask : wr

    task automatic rd_reg(input logic [7:0] a);
        int t = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && t < 100);
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
        if (t >= 100) fail_count++;
    endtask : rd_reg

    function automatic logic hit(input int s);
        if (s == 0) return a_irq === 1'b1;
        if (s == 1) return b_irq === 1'b1;
        return cmp !== cmp_q;
    endfunction : hit

    // Cycles between two successive events of one source
    task automatic gap(input int s);
        n = 0;
        do begin @(posedge aclk); n++; end while (!hit(s) && n < 9000);
        n = 0;
        do begin @(posedge aclk); n++; end while (!hit(s) && n < 9000);
    endtask : gap

    task automatic hi_count(input int len);
        h = 0;
        repeat (len) begin
            @(posedge aclk);
            if (cmp === 1'b1) h++;
        end
    endtask : hi_count

    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (60000) @(posedge aclk);
        fail_count++;
        print_verdict;
    end

    initial begin
        rows[0] = '{`DTC_OFF_PERIOD, 32'hffffff5a, 32'h5a, OK};
        rows[1] = '{`DTC_OFF_DUTY, 32'h3c, 32'h3c, OK};
        rows[2] = '{`DTC_OFF_HIGH, 32'h0e, 32'h0e, OK};
        rows[3] = '{8'h24, 32'h11, 32'h0, ERR};
        rows[4] = '{8'h11, 32'h22, 32'h0, ERR};
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            check("write resp", rs, rows[i].r);
            rd_reg(rows[i].a);
            check("read data", rd, rows[i].q);
            check("read resp", rs, rows[i].r);
        end
        wstrb <= 4'h0;
        wr(`DTC_OFF_DUTY, 32'h77);
        wstrb <= 4'hf;
        rd_reg(`DTC_OFF_DUTY);
        check("masked write", rd, 32'h3c);
        // Event counting, stop and restart
        wr(`DTC_OFF_A_DATA, 32'hff);
        wr(`DTC_OFF_A_MODE, 32'h1f);
        u_dtc_pin_model.events(5);
        rd_reg(`DTC_OFF_A_DATA);
        check("event count", rd, 32'h5);
        wr(`DTC_OFF_A_MODE, 32'h1c);
        u_dtc_pin_model.events(2);
        rd_reg(`DTC_OFF_A_DATA);
        check("stopped count", rd, 32'h5);
        wr(`DTC_OFF_A_MODE, 32'h1f);
        rd_reg(`DTC_OFF_A_DATA);
        check("restart count", rd, 32'h0);
        // Capture on a rising trigger edge, then interrupts for each edge mode
        wr(`DTC_OFF_PINS, 32'h02);
        wr(`DTC_OFF_A_MODE, 32'h3f);
        u_dtc_pin_model.events(3);
        u_dtc_pin_model.pulse(0);
        u_dtc_pin_model.events(2);
        rd_reg(`DTC_OFF_A_DATA);
        check("captured value", rd, 32'h3);
        wr(`DTC_OFF_A_MODE, 32'h1e);
        rd_reg(`DTC_OFF_A_DATA);
        check("count after capture", rd, 32'h2);
        for (int e = 1; e <= 3; e++) begin
            wr(`DTC_OFF_PINS, 32'(e));
            n = x_hits;
            u_dtc_pin_model.pulse(0);
            check("edge interrupts", x_hits - n, enum_hits[e - 1]);
        end
        // Prescaler ratios with a zero match
        wr(`DTC_OFF_A_DATA, 32'h0);
        for (int s = 0; s < 7; s++) begin
            wr(`DTC_OFF_A_MODE, 32'((s << 2) | 3));
            gap(0);
            check("timer a period", n, ediv[s]);
        end
        wr(`DTC_OFF_B_DATA, 32'h0);
        for (int s = 0; s < 3; s++) begin
            wr(`DTC_OFF_B_MODE, 32'((s << 2) | 3));
            gap(1);
            check("timer b period", n, bdiv[s]);
        end
        wr(`DTC_OFF_A_MODE, 32'h07);
        wr(`DTC_OFF_B_MODE, 32'h0f);
        gap(1);
        check("borrowed clock", n, 32'h4);
        // Chained count: match 0x0100 is 257 ticks of /2
        wr(`DTC_OFF_A_MODE, 32'h03);
        wr(`DTC_OFF_B_DATA, 32'h1);
        wr(`DTC_OFF_B_MODE, 32'h4f);
        @(posedge aclk);
        h = b_hits;
        gap(0);
        check("wide period", n, 32'd514);
        check("timer b quiet", b_hits - h, 32'h0);
        // Compare toggle every match + 1 cycles
        wr(`DTC_OFF_PINS, 32'h10);
        wr(`DTC_OFF_B_DATA, 32'h2);
        wr(`DTC_OFF_B_MODE, 32'h03);
        gap(2);
        check("compare half period", n, 32'h3);
        // Pulse mode loaded while stopped, period 0x105, duty 0x100
        wr(`DTC_OFF_B_MODE, 32'h00);
        wr(`DTC_OFF_PERIOD, 32'h05);
        wr(`DTC_OFF_DUTY, 32'h00);
        wr(`DTC_OFF_HIGH, 32'h05);
        wr(`DTC_OFF_B_MODE, 32'ha3);
        hi_count(524);
        check("duty time", h, 32'd512);
        wr(`DTC_OFF_HIGH, 32'h04);
        repeat (300) @(posedge aclk);
        hi_count(262);
        check("zero duty", h, 32'h0);
        wr(`DTC_OFF_HIGH, 32'h05);
        wr(`DTC_OFF_DUTY, 32'h05);
        repeat (300) @(posedge aclk);
        hi_count(262);
        check("full duty", h, 32'd262);
        wr(`DTC_OFF_B_MODE, 32'h23);
        hi_count(262);
        check("low polarity", h, 32'h0);
        print_verdict;
    end
endmodule : tb_top

bind dtc_timer dtc_timer_checker u_dtc_timer_checker (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .capture_trigger_pin(capture_trigger_pin), .timer_a_irq(timer_a_irq),
    .timer_b_irq(timer_b_irq), .ext_irq(ext_irq));
